// File: hw/msw_pkg.sv
package msw_pkg;

	// ==========================================
	// Register indices (byte address is four times the index)
	localparam int unsigned ADDR_W = 8;
	localparam logic [5:0] IDX_WAKE_GLOBAL_ENABLE = 6'h01;
	localparam logic [5:0] IDX_WAKE_STATUS_TWO = 6'h03;
	localparam logic [5:0] IDX_WAKE_ENABLE_TWO = 6'h06;
	localparam logic [5:0] IDX_WATCHDOG_UNITS = 6'h11;
	localparam logic [5:0] IDX_WATCHDOG_COUNT_VALUE = 6'h12;
	localparam logic [5:0] IDX_WATCHDOG_IRQ_CONFIG = 6'h13;
	localparam logic [5:0] IDX_WATCHDOG_CONTROL = 6'h14;
	localparam logic [5:0] IDX_SYSMGMT_STATUS_THREE = 6'h18;
	localparam logic [5:0] IDX_SYSMGMT_ENABLE_THREE = 6'h19;
	localparam logic [5:0] IDX_PIN_CONFIG = 6'h20;

	// ==========================================
	// Field positions and codes
	localparam int unsigned UNITS_MINUTE_BIT = 7;
	localparam int unsigned WAKE_GLOBAL_BIT = 0;
	localparam int unsigned WAKE_TIMER_BIT = 7;
	localparam int unsigned SMI_TIMER_BIT = 0;
	localparam int unsigned CTRL_STATUS_BIT = 0;
	localparam int unsigned CTRL_FORCE_BIT = 2;
	localparam int unsigned PIN_POLARITY_BIT = 1;
	localparam int unsigned TIMER_ALT_LSB = 2;
	localparam int unsigned SMI_ALT_LSB = 4;
	localparam int unsigned MAP_LSB = 4;
	localparam logic [1:0] ALT_SMI_FUNC = 2'h1;
	localparam logic [1:0] ALT_TIMER_FUNC = 2'h2;
	localparam logic [3:0] MAP_OFF = 4'h0;
	localparam logic [7:0] COUNT_OFF = 8'h00;
	localparam logic [7:0] COUNT_LAST = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Timing
	localparam longint unsigned SECOND_S = 1;
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICKS_PER_SECOND = int'(SECOND_S * CLK_HZ);
	localparam int unsigned PRESC_W = 28;
	localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3c;

	// ==========================================
	// Whole state of the block
	typedef struct packed {
		logic aw_full;
		logic [ADDR_W-1:0] awaddr;
		logic w_full;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] count;
		logic [PRESC_W-1:0] presc;
		logic [5:0] sec_in_min;
		logic [7:0] units;
		logic [7:0] irq_cfg;
		logic [7:0] wake_glob;
		logic [7:0] wake_en2;
		logic wake_sts;
		logic [7:0] sysmgmt_enable_three;
		logic smi_sts;
		logic [7:0] pin_cfg;
		logic status;
		logic status_prev;
		logic wake_act;
		logic smi_act;
		logic tpin;
		logic sirq_req;
	} msw_state_t;

endpackage

// File: hw/msw_watchdog.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// R1: Timeout 1..255 in seconds or minutes
// R2: Zero value disables; zero after reset
// R3: Nonzero write reloads and starts countdown
// R4: Reaching zero stops counter, sets status
// R5: Software may set or clear status
// R6: Event only on status rising edge
// R7: Event sets wake status; gated wake pin
// R8: Event sets sysmgmt status; gated sysmgmt pin
// R9: Timer pin driven only with code 10
// R10: Serial IRQ slot from map; 0000 off
// R11: Timer pin active high; polarity inverts
// R12: Force bit zeroes count, sets status
// R13: Prescaler ticks seconds or minutes
module msw_watchdog #(
	parameter int unsigned TICKS_PER_SECOND = msw_pkg::TICKS_PER_SECOND
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [msw_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [msw_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic wake_event_pin_n_out,
	output logic sysmgmt_irq_pin_n_out,
	output logic sysmgmt_irq_pin_oe_out,
	output logic timer_output_gpio_out,
	output logic timer_output_gpio_oe_out,
	output logic serial_irq_request_out,
	output logic [3:0] serial_irq_slot_out
);

	localparam logic [msw_pkg::PRESC_W-1:0] PRESC_LAST =
		msw_pkg::PRESC_W'(TICKS_PER_SECOND - 1);
	localparam logic [5:0] MIN_LAST = msw_pkg::SECONDS_PER_MINUTE - 6'h01;

	// Byte address bits below the register index
	localparam int unsigned IDX_LSB =
		msw_pkg::ADDR_W - $bits(msw_pkg::IDX_WATCHDOG_UNITS);
	localparam int unsigned ALT_W = $bits(msw_pkg::ALT_SMI_FUNC);
	localparam int unsigned MAP_W = $bits(msw_pkg::MAP_OFF);

	// R2: all registers zero, timer off
	localparam msw_pkg::msw_state_t RESET_STATE = '0;

	// ==========================================
	// Decode helpers

	// Register index from a byte address
	function automatic logic [5:0] idx_of(
		input logic [msw_pkg::ADDR_W-1:0] addr
	);
		return addr[msw_pkg::ADDR_W-1:IDX_LSB];
	endfunction

	// Whether an index names a register of this block
	function automatic logic idx_known(
		input logic [5:0] idx
	);
		logic hit;
		hit = 1'b0;
		case (idx)
			msw_pkg::IDX_WAKE_GLOBAL_ENABLE,
			msw_pkg::IDX_WAKE_STATUS_TWO,
			msw_pkg::IDX_WAKE_ENABLE_TWO,
			msw_pkg::IDX_WATCHDOG_UNITS,
			msw_pkg::IDX_WATCHDOG_COUNT_VALUE,
			msw_pkg::IDX_WATCHDOG_IRQ_CONFIG,
			msw_pkg::IDX_WATCHDOG_CONTROL,
			msw_pkg::IDX_SYSMGMT_STATUS_THREE,
			msw_pkg::IDX_SYSMGMT_ENABLE_THREE,
			msw_pkg::IDX_PIN_CONFIG: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// Read value of one register
	function automatic logic [7:0] read_byte(
		input msw_pkg::msw_state_t s,
		input logic [5:0] idx
	);
		logic [7:0] v;
		v = '0;
		case (idx)
			msw_pkg::IDX_WAKE_GLOBAL_ENABLE: begin
				v = s.wake_glob;
			end
			msw_pkg::IDX_WAKE_STATUS_TWO: begin
				v[msw_pkg::WAKE_TIMER_BIT] = s.wake_sts;
			end
			msw_pkg::IDX_WAKE_ENABLE_TWO: begin
				v = s.wake_en2;
			end
			msw_pkg::IDX_WATCHDOG_UNITS: begin
				v = s.units;
			end
			msw_pkg::IDX_WATCHDOG_COUNT_VALUE: begin
				v = s.count;
			end
			msw_pkg::IDX_WATCHDOG_IRQ_CONFIG: begin
				v = s.irq_cfg;
			end
			// R12: force bit always reads zero
			msw_pkg::IDX_WATCHDOG_CONTROL: begin
				v[msw_pkg::CTRL_STATUS_BIT] = s.status;
			end
			msw_pkg::IDX_SYSMGMT_STATUS_THREE: begin
				v[msw_pkg::SMI_TIMER_BIT] = s.smi_sts;
			end
			msw_pkg::IDX_SYSMGMT_ENABLE_THREE: begin
				v = s.sysmgmt_enable_three;
			end
			msw_pkg::IDX_PIN_CONFIG: begin
				v = s.pin_cfg;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction

	// ==========================================
	// State and helper nets

	msw_pkg::msw_state_t s_q;
	msw_pkg::msw_state_t s_d;

	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_go;
	logic wr_sel;
	logic [msw_pkg::ADDR_W-1:0] wr_addr;
	logic [5:0] wr_idx;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic sec_tick;
	logic minute_wrap;
	logic unit_tick;
	logic expire;
	logic rise;

	// ==========================================
	// Bus handshakes

	// One write and one read in flight at most
	assign s_axi_awready_out = !s_q.aw_full && !s_q.bvalid;
	assign s_axi_wready_out = !s_q.w_full && !s_q.bvalid;
	assign s_axi_arready_out = !s_q.rvalid;

	assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_take = s_axi_arvalid_in && s_axi_arready_out;

	// Address and data may arrive in either order
	assign wr_go = (s_q.aw_full || aw_take) && (s_q.w_full || w_take) && !s_q.bvalid;
	assign wr_addr = s_q.aw_full ? s_q.awaddr : s_axi_awaddr_in;
	assign wr_byte = s_q.w_full ? s_q.wdata : s_axi_wdata_in[7:0];
	assign wr_lane = s_q.w_full ? s_q.wstrb0 : s_axi_wstrb_in[0];
	assign wr_idx = idx_of(wr_addr);
	assign wr_sel = wr_go && wr_lane;

	// ==========================================
	// Time base

	// R13: prescaler gives one pulse per second
	assign sec_tick = (s_q.count != msw_pkg::COUNT_OFF) && (s_q.presc == PRESC_LAST);
	assign minute_wrap = s_q.sec_in_min == MIN_LAST;

	// R1: units bit picks seconds or minutes
	assign unit_tick = sec_tick && (!s_q.units[msw_pkg::UNITS_MINUTE_BIT] || minute_wrap);

	// R4: last unit elapses at count one
	assign expire = unit_tick && (s_q.count == msw_pkg::COUNT_LAST);

	// R6: event only on status rising edge
	assign rise = s_q.status && !s_q.status_prev;

	// ==========================================
	// Next state

	always_comb begin
		s_d = s_q;

		// Write address and data capture
		if (aw_take) begin
			s_d.aw_full = 1'b1;
			s_d.awaddr = s_axi_awaddr_in;
		end
		if (w_take) begin
			s_d.w_full = 1'b1;
			s_d.wdata = s_axi_wdata_in[7:0];
			s_d.wstrb0 = s_axi_wstrb_in[0];
		end
		if (wr_go) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = idx_known(wr_idx) ? msw_pkg::RESP_OKAY : msw_pkg::RESP_SLVERR;
		end
		if (s_q.bvalid && s_axi_bready_in) begin
			s_d.bvalid = 1'b0;
		end

		// Read answer
		if (s_q.rvalid && s_axi_rready_in) begin
			s_d.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = {24'h0, read_byte(s_q, idx_of(s_axi_araddr_in))};
			s_d.rresp = idx_known(idx_of(s_axi_araddr_in)) ?
				msw_pkg::RESP_OKAY : msw_pkg::RESP_SLVERR;
		end

		// R13: prescaler idles while timer is off
		if (s_q.count == msw_pkg::COUNT_OFF) begin
			s_d.presc = '0;
			s_d.sec_in_min = '0;
		end else if (sec_tick) begin
			s_d.presc = '0;
			s_d.sec_in_min = minute_wrap ? '0 : s_q.sec_in_min + 6'h01;
		end else begin
			s_d.presc = s_q.presc + 1'b1;
		end

		// R4: count down, stop at zero
		if (unit_tick) begin
			s_d.count = s_q.count - msw_pkg::COUNT_LAST;
		end

		// Register writes override the countdown
		if (wr_sel) begin
			case (wr_idx)
				msw_pkg::IDX_WAKE_GLOBAL_ENABLE: begin
					s_d.wake_glob = wr_byte;
				end
				msw_pkg::IDX_WAKE_STATUS_TWO: begin
					if (wr_byte[msw_pkg::WAKE_TIMER_BIT]) begin
						s_d.wake_sts = 1'b0;
					end
				end
				msw_pkg::IDX_WAKE_ENABLE_TWO: begin
					s_d.wake_en2 = wr_byte;
				end
				// R1: units register
				msw_pkg::IDX_WATCHDOG_UNITS: begin
					s_d.units = wr_byte;
				end
				// R2 R3: zero stops, nonzero reloads
				msw_pkg::IDX_WATCHDOG_COUNT_VALUE: begin
					s_d.count = wr_byte;
					s_d.presc = '0;
					s_d.sec_in_min = '0;
				end
				msw_pkg::IDX_WATCHDOG_IRQ_CONFIG: begin
					s_d.irq_cfg = wr_byte;
				end
				// R5 R12: direct status write, forced timeout
				msw_pkg::IDX_WATCHDOG_CONTROL: begin
					s_d.status = wr_byte[msw_pkg::CTRL_STATUS_BIT];
					if (wr_byte[msw_pkg::CTRL_FORCE_BIT]) begin
						s_d.count = msw_pkg::COUNT_OFF;
						s_d.status = 1'b1;
					end
				end
				msw_pkg::IDX_SYSMGMT_STATUS_THREE: begin
					if (wr_byte[msw_pkg::SMI_TIMER_BIT]) begin
						s_d.smi_sts = 1'b0;
					end
				end
				msw_pkg::IDX_SYSMGMT_ENABLE_THREE: begin
					s_d.sysmgmt_enable_three = wr_byte;
				end
				msw_pkg::IDX_PIN_CONFIG: begin
					s_d.pin_cfg = wr_byte;
				end
				default: begin
					s_d.pin_cfg = s_d.pin_cfg;
				end
			endcase
		end

		// R4: expiry sets status, beats a clear
		if (expire) begin
			s_d.status = 1'b1;
		end

		// R6: edge detector on the status bit
		s_d.status_prev = s_q.status;

		// R7 R8: event latches both status flags
		if (rise) begin
			s_d.wake_sts = 1'b1;
			s_d.smi_sts = 1'b1;
		end

		// R7: wake pin needs both enables
		s_d.wake_act = s_d.wake_sts &&
			s_d.wake_glob[msw_pkg::WAKE_GLOBAL_BIT] &&
			s_d.wake_en2[msw_pkg::WAKE_TIMER_BIT];

		// R8: sysmgmt pin needs function code and enable
		s_d.smi_act = s_d.smi_sts &&
			s_d.sysmgmt_enable_three[msw_pkg::SMI_TIMER_BIT] &&
			(s_d.pin_cfg[msw_pkg::SMI_ALT_LSB +: ALT_W] == msw_pkg::ALT_SMI_FUNC);

		// R9 R11: timer pin level and polarity
		s_d.tpin = ((s_d.pin_cfg[msw_pkg::TIMER_ALT_LSB +: ALT_W] == msw_pkg::ALT_TIMER_FUNC) &&
			s_d.status) ^ s_d.pin_cfg[msw_pkg::PIN_POLARITY_BIT];

		// R10: serial request only with nonzero slot
		s_d.sirq_req = s_d.status &&
			(s_d.irq_cfg[msw_pkg::MAP_LSB +: MAP_W] != msw_pkg::MAP_OFF);
	end

	// ==========================================
	// State register

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs

	assign s_axi_bvalid_out = s_q.bvalid;
	assign s_axi_bresp_out = s_q.bresp;
	assign s_axi_rvalid_out = s_q.rvalid;
	assign s_axi_rdata_out = s_q.rdata;
	assign s_axi_rresp_out = s_q.rresp;

	// Active low pins
	assign wake_event_pin_n_out = !s_q.wake_act;
	assign sysmgmt_irq_pin_n_out = !s_q.smi_act;

	// R8: sysmgmt pin driven only in its function
	assign sysmgmt_irq_pin_oe_out =
		s_q.pin_cfg[msw_pkg::SMI_ALT_LSB +: ALT_W] == msw_pkg::ALT_SMI_FUNC;

	// R9: timer pin driven only with code 10
	assign timer_output_gpio_out = s_q.tpin;
	assign timer_output_gpio_oe_out =
		s_q.pin_cfg[msw_pkg::TIMER_ALT_LSB +: ALT_W] == msw_pkg::ALT_TIMER_FUNC;

	// R10: slot number from the mapping field
	assign serial_irq_request_out = s_q.sirq_req;
	assign serial_irq_slot_out = s_q.irq_cfg[msw_pkg::MAP_LSB +: MAP_W];

endmodule

// File: tb/msw_watchdog_checker.sv
`timescale 1ns/10ps
// ==========================================
// Port checks
module msw_checker (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic sysmgmt_irq_pin_n_out,
	input wire logic sysmgmt_irq_pin_oe_out,
	input wire logic wake_event_pin_n_out,
	input wire logic serial_irq_request_out,
	input wire logic [3:0] serial_irq_slot_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	property p_bh; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped early");
	property p_wk; $rose(rst_n_in) |-> wake_event_pin_n_out; endproperty
	a_wk: assert property (p_wk) else $error("wake pin active at reset");
	property p_sq; $rose(rst_n_in) |-> !serial_irq_request_out; endproperty
	a_sq: assert property (p_sq) else $error("serial irq at reset");
	property p_sl; serial_irq_request_out |-> serial_irq_slot_out != 4'h0; endproperty
	a_sl: assert property (p_sl) else $error("serial irq in slot zero");
	property p_rh; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out; endproperty
	a_rh: assert property (p_rh) else $error("rvalid dropped early");
	property p_sp; !sysmgmt_irq_pin_n_out |-> sysmgmt_irq_pin_oe_out; endproperty
	a_sp: assert property (p_sp) else $error("sysmgmt pin active while not selected");
endmodule

// File: tb/msw_watchdog_tb.sv
`timescale 1ns/10ps
module msw_watchdog_tb;
	logic clk_sys_in = '0, rst_n_in = '0, s_axi_awvalid_in = '0, s_axi_wvalid_in = '0;
	logic s_axi_bready_in = '0, s_axi_arvalid_in = '0, s_axi_rready_in = '0;
	logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
	logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf, serial_irq_slot_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, wake_event_pin_n_out, sysmgmt_irq_pin_n_out, sysmgmt_irq_pin_oe_out;
	logic timer_output_gpio_out, timer_output_gpio_oe_out, serial_irq_request_out;
	int num_errors = 0, checked = 0, n = 0;
	msw_watchdog #(.TICKS_PER_SECOND(4)) dut_u (.*);
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (++n > 9999) begin num_errors++; end_of_test(); end
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		s_axi_awaddr_in <= {i, 2'h0};
		s_axi_wdata_in <= {24'h0, d};
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic chk(input logic [5:0] i, input logic [7:0] e);
		s_axi_araddr_in <= {i, 2'h0};
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'b0;
		checked++;
		if (s_axi_rdata_out[7:0] !== e) begin
			num_errors++;
			$display("CHECK FAILED reg %h expected %h seen %h", i, e, s_axi_rdata_out[7:0]);
		end
		@(posedge clk_sys_in);
	endtask
	task automatic t_expire();
		chk(6'h12, 8'h00);
		wr(6'h11, 8'h00);
		wr(6'h12, 8'h02);
		chk(6'h12, 8'h02);
		repeat (40) @(posedge clk_sys_in);
		chk(6'h14, 8'h01);
	endtask
	task automatic t_force();
		wr(6'h14, 8'h00);
		chk(6'h14, 8'h00);
		wr(6'h12, 8'h09);
		wr(6'h14, 8'h04);
		chk(6'h12, 8'h00);
		chk(6'h14, 8'h01);
	endtask
	task automatic pin(input string nm, input logic e, input logic s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic t_route();
		wr(6'h14, 8'h00);
		wr(6'h03, 8'h80);
		wr(6'h18, 8'h01);
		wr(6'h01, 8'h01);
		wr(6'h06, 8'h80);
		wr(6'h19, 8'h01);
		wr(6'h20, 8'h18);
		wr(6'h13, 8'h50);
		pin("wake_pin_idle", 1'b1, wake_event_pin_n_out);
		pin("sysmgmt_pin_idle", 1'b1, sysmgmt_irq_pin_n_out);
		wr(6'h14, 8'h04);
		pin("wake_pin", 1'b0, wake_event_pin_n_out);
		pin("sysmgmt_pin", 1'b0, sysmgmt_irq_pin_n_out);
		pin("sysmgmt_oe", 1'b1, sysmgmt_irq_pin_oe_out);
		pin("timer_pin", 1'b1, timer_output_gpio_out);
		pin("timer_oe", 1'b1, timer_output_gpio_oe_out);
		pin("serial_req", 1'b1, serial_irq_request_out);
		pin("slot_b0", 1'b1, serial_irq_slot_out[0]);
		pin("slot_b2", 1'b1, serial_irq_slot_out[2]);
		pin("slot_b1", 1'b0, serial_irq_slot_out[1]);
		chk(6'h03, 8'h80);
		chk(6'h18, 8'h01);
		wr(6'h20, 8'h1a);
		pin("timer_pin_inv", 1'b0, timer_output_gpio_out);
		wr(6'h14, 8'h00);
		pin("serial_req_off", 1'b0, serial_irq_request_out);
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		t_expire();
		t_force();
		t_route();
		end_of_test();
	end
endmodule
bind msw_watchdog msw_checker chk_u (.*);
